// ==== verilog/cmbx_params.svh ====
`ifndef CMBX_PARAMS_SVH
`define CMBX_PARAMS_SVH
`define CMBX_OFF_CMD 8'h00
`define CMBX_OFF_OPND 8'h04
`define CMBX_OFF_FLAGS 8'h08
`define CMBX_OFF_PC 8'h0C
`define CMBX_OFF_PAGE 8'h10
`define CMBX_OFF_REGSEL 8'h14
`define CMBX_OFF_REGDAT 8'h18
`define CMBX_OFF_STATUS 8'h1C
`define CMBX_CMD_TWO_WORD 6
`define CMBX_RST_PC 22'h00_0000
`define CMBX_RST_FLAGS 8'h00
`define CMBX_RST_PAGE 6'h00
`define CMBX_FLAG_C 0
`define CMBX_FLAG_Z 1
`define CMBX_FLAG_N 2
`define CMBX_FLAG_V 3
`define CMBX_FLAG_S 4
`define CMBX_FLAG_H 5
`define CMBX_FLAG_T 6
`define CMBX_FLAG_I 7
`define CMBX_PTR_X 5'h1A
`define CMBX_PTR_Z 5'h1E
`define CMBX_CYC_PRODUCT 3'h2
`define CMBX_CYC_TAKEN 3'h2
`define CMBX_CYC_JUMP 3'h2
`define CMBX_CYC_CALL 3'h3
`define CMBX_CYC_DIRECT 3'h2
`define CMBX_CYC_PREDEC 3'h2
`endif

// ==== verilog/cmbx_pkg.sv ====
package cmbx_pkg;
  typedef enum logic [5:0] {
    NOP_OP, UNSIGNED_PRODUCT_OP, SIGNED_PRODUCT_OP, MIXED_SIGN_PRODUCT_OP,
    FRAC_UNSIGNED_PRODUCT_OP, FRAC_SIGNED_PRODUCT_OP, FRAC_MIXED_PRODUCT_OP,
    CIPHER_STEP_OP, BRANCH_FLAG_BIT_SET, BRANCH_FLAG_BIT_CLEAR,
    BRANCH_SIGNED_GE, BRANCH_SIGNED_LT, BRANCH_UNSIGNED_GE, BRANCH_UNSIGNED_LT,
    BRANCH_CARRY_ONE, BRANCH_CARRY_ZERO, BRANCH_HALFCARRY_ONE,
    BRANCH_HALFCARRY_ZERO, BRANCH_IRQ_ON, BRANCH_IRQ_OFF, BRANCH_OVERFLOW_ONE,
    BRANCH_OVERFLOW_ZERO, BRANCH_TBIT_ONE, BRANCH_TBIT_ZERO, Z_POINTER_JUMP,
    FAR_Z_POINTER_JUMP, Z_POINTER_CALL, FAR_Z_POINTER_CALL,
    COMPARE_SKIP_EQUAL, SKIP_REG_BIT_CLEAR, SKIP_REG_BIT_SET,
    SKIP_IO_BIT_CLEAR, SKIP_IO_BIT_SET, DIRECT_DATA_LOAD, POINTER_LOAD_INC,
    POINTER_LOAD_DEC, COMPARE_REGS, COMPARE_REGS_CARRY, COMPARE_IMMEDIATE
  } cmbx_op_t;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT} cmbx_fsm_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cmbx_avs_req_t;
  typedef struct packed {
    logic [15:0] prod;
    logic zero;
    logic carry;
  } cmbx_mul_res_t;
  typedef struct packed {
    cmbx_fsm_t st;
    logic [2:0] cnt;
    cmbx_op_t op;
    logic two_word;
    logic [31:0] opnd;
    logic [21:0] pc;
    logic [7:0] flags;
    logic [5:0] page;
    logic [4:0] regsel;
    logic [31:0][7:0] regs;
    logic waitreq;
    logic [31:0] rdata;
    logic push;
    logic [21:0] push_addr;
    logic dm_rd;
    logic [15:0] dm_addr;
    logic [5:0] io_addr;
    logic [2:0] last_cyc;
    logic prev_cipher;
  } cmbx_state_t;
endpackage

// ==== verilog/cmbx_mul.sv ====
`timescale 1ns/1ps
module cmbx_mul (
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  input wire logic i_a_signed,
  input wire logic i_b_signed,
  input wire logic i_frac,
  output cmbx_pkg::cmbx_mul_res_t o_res
);
  logic signed [17:0] prod;
  logic [15:0] raw;
  logic [15:0] res;

  // Nine-bit operands let one signed multiplier cover all three sign mixes.
  assign prod = $signed({i_a_signed & i_a[7], i_a})
              * $signed({i_b_signed & i_b[7], i_b});
  assign raw = prod[15:0];
  assign res = i_frac ? {raw[14:0], 1'b0} : raw;
  assign o_res.prod = res;
  assign o_res.carry = raw[15];
  assign o_res.zero = (res == 16'h0000);
endmodule // cmbx_mul

// ==== verilog/cmbx_cipher.sv ====
`timescale 1ns/1ps
module cmbx_cipher (
  input wire logic [127:0] i_block,
  input wire logic [3:0] i_key,
  input wire logic i_decrypt,
  output logic [127:0] o_block
);
  logic [63:0] f_hi;
  logic [63:0] f_lo;

  // One balanced round, so that decrypting undoes encrypting exactly.
  function automatic logic [63:0] round_fn(input logic [63:0] r,
                                           input logic [3:0] k);
    logic [127:0] t;
    t = {r, r} << ({3'b000, k} + 7'h01);
    round_fn = t[127:64] ^ {16{k}};
  endfunction

  assign f_hi = round_fn(i_block[127:64], i_key);
  assign f_lo = round_fn(i_block[63:0], i_key);
  assign o_block = i_decrypt ? {i_block[63:0] ^ f_hi, i_block[127:64]}
                             : {i_block[63:0], i_block[127:64] ^ f_lo};
endmodule // cmbx_cipher

// ==== verilog/cmbx_top.sv ====
`timescale 1ns/1ps
`include "cmbx_params.svh"
module cmbx_top (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [15:0] o_dmem_addr,
  output logic o_dmem_read,
  input wire logic [7:0] i_dmem_rdata,
  output logic [5:0] o_io_addr,
  input wire logic [7:0] i_io_rdata,
  output logic o_push_valid,
  output logic [21:0] o_push_addr,
  output logic o_busy
);
  cmbx_pkg::cmbx_state_t s_q;
  cmbx_pkg::cmbx_state_t s_d;
  cmbx_pkg::cmbx_avs_req_t req;
  cmbx_pkg::cmbx_mul_res_t mres;
  logic [127:0] ciph_out;
  logic [7:0] rd_v;
  logic [7:0] rr_v;
  logic mul_a_signed;
  logic mul_b_signed;
  logic mul_frac;
  logic busy_w;

  assign req = '{read: i_avs_read, write: i_avs_write, addr: i_avs_address,
                 be: i_avs_byteenable, wdata: i_avs_writedata};
  assign rd_v = s_q.regs[s_q.opnd[4:0]];
  assign rr_v = s_q.regs[s_q.opnd[9:5]];
  assign busy_w = (s_q.st != cmbx_pkg::ST_IDLE);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction

  function automatic logic [4:0] ptr_base(input logic [1:0] sel);
    ptr_base = `CMBX_PTR_X + {2'b00, sel, 1'b0};
  endfunction

  function automatic logic [15:0] ptr_get(input logic [31:0][7:0] r,
                                          input logic [4:0] b);
    ptr_get = {r[b + 5'h01], r[b]};
  endfunction

  function automatic logic br_cond(input cmbx_pkg::cmbx_op_t op,
                                   input logic [7:0] f,
                                   input logic [2:0] s);
    logic nv;
    nv = f[`CMBX_FLAG_N] ^ f[`CMBX_FLAG_V];
    case (op)
      cmbx_pkg::BRANCH_FLAG_BIT_SET: br_cond = f[s];
      cmbx_pkg::BRANCH_FLAG_BIT_CLEAR: br_cond = !f[s];
      cmbx_pkg::BRANCH_SIGNED_GE: br_cond = !nv;
      cmbx_pkg::BRANCH_SIGNED_LT: br_cond = nv;
      cmbx_pkg::BRANCH_UNSIGNED_GE: br_cond = !f[`CMBX_FLAG_C];
      cmbx_pkg::BRANCH_UNSIGNED_LT: br_cond = f[`CMBX_FLAG_C];
      cmbx_pkg::BRANCH_CARRY_ONE: br_cond = f[`CMBX_FLAG_C];
      cmbx_pkg::BRANCH_CARRY_ZERO: br_cond = !f[`CMBX_FLAG_C];
      cmbx_pkg::BRANCH_HALFCARRY_ONE: br_cond = f[`CMBX_FLAG_H];
      cmbx_pkg::BRANCH_HALFCARRY_ZERO: br_cond = !f[`CMBX_FLAG_H];
      cmbx_pkg::BRANCH_IRQ_ON: br_cond = f[`CMBX_FLAG_I];
      cmbx_pkg::BRANCH_IRQ_OFF: br_cond = !f[`CMBX_FLAG_I];
      cmbx_pkg::BRANCH_OVERFLOW_ONE: br_cond = f[`CMBX_FLAG_V];
      cmbx_pkg::BRANCH_OVERFLOW_ZERO: br_cond = !f[`CMBX_FLAG_V];
      cmbx_pkg::BRANCH_TBIT_ONE: br_cond = f[`CMBX_FLAG_T];
      cmbx_pkg::BRANCH_TBIT_ZERO: br_cond = !f[`CMBX_FLAG_T];
      default: br_cond = 1'b0;
    endcase
  endfunction

  // Flags of d - r - cin; the difference itself is thrown away.
  function automatic logic [7:0] cmp_flags(input logic [7:0] f,
                                           input logic [7:0] d,
                                           input logic [7:0] r,
                                           input logic cin,
                                           input logic chain);
    logic [7:0] x;
    logic [7:0] o;
    x = d - r - {7'h00, cin};
    o = f;
    o[`CMBX_FLAG_H] = (!d[3] & r[3]) | (r[3] & x[3]) | (x[3] & !d[3]);
    o[`CMBX_FLAG_C] = (!d[7] & r[7]) | (r[7] & x[7]) | (x[7] & !d[7]);
    o[`CMBX_FLAG_V] = (d[7] & !r[7] & !x[7]) | (!d[7] & r[7] & x[7]);
    o[`CMBX_FLAG_N] = x[7];
    o[`CMBX_FLAG_S] = x[7] ^ o[`CMBX_FLAG_V];
    o[`CMBX_FLAG_Z] = (x == 8'h00) & (!chain | f[`CMBX_FLAG_Z]);
    cmp_flags = o;
  endfunction

  function automatic logic [31:0] rd_word(input cmbx_pkg::cmbx_state_t s,
                                          input logic [7:0] a);
    case (a)
      `CMBX_OFF_CMD: rd_word = {25'h000_0000, s.two_word, s.op};
      `CMBX_OFF_OPND: rd_word = s.opnd;
      `CMBX_OFF_FLAGS: rd_word = {24'h00_0000, s.flags};
      `CMBX_OFF_PC: rd_word = {10'h000, s.pc};
      `CMBX_OFF_PAGE: rd_word = {26'h000_0000, s.page};
      `CMBX_OFF_REGSEL: rd_word = {27'h000_0000, s.regsel};
      `CMBX_OFF_REGDAT: rd_word = {24'h00_0000, s.regs[s.regsel]};
      `CMBX_OFF_STATUS: rd_word = {28'h000_0000, s.last_cyc,
                                   s.st != cmbx_pkg::ST_IDLE};
      default: rd_word = 32'h0000_0000;
    endcase
  endfunction

  always_comb begin
    case (s_q.op)
      cmbx_pkg::SIGNED_PRODUCT_OP, cmbx_pkg::FRAC_SIGNED_PRODUCT_OP: begin
        mul_a_signed = 1'b1;
        mul_b_signed = 1'b1;
      end
      cmbx_pkg::MIXED_SIGN_PRODUCT_OP, cmbx_pkg::FRAC_MIXED_PRODUCT_OP: begin
        mul_a_signed = 1'b1;
        mul_b_signed = 1'b0;
      end
      default: begin
        mul_a_signed = 1'b0;
        mul_b_signed = 1'b0;
      end
    endcase
    mul_frac = (s_q.op == cmbx_pkg::FRAC_UNSIGNED_PRODUCT_OP)
            || (s_q.op == cmbx_pkg::FRAC_SIGNED_PRODUCT_OP)
            || (s_q.op == cmbx_pkg::FRAC_MIXED_PRODUCT_OP);
  end

  cmbx_mul u_mul (
    .i_a(rd_v),
    .i_b(rr_v),
    .i_a_signed(mul_a_signed),
    .i_b_signed(mul_b_signed),
    .i_frac(mul_frac),
    .o_res(mres)
  );

  cmbx_cipher u_cipher (
    .i_block(s_q.regs[15:0]),
    .i_key(s_q.opnd[19:16]),
    .i_decrypt(s_q.flags[`CMBX_FLAG_H]),
    .o_block(ciph_out)
  );

  always_comb begin
    logic [31:0] w;
    logic [2:0] ncyc;
    logic [21:0] npc;
    logic [4:0] pb;
    logic [15:0] ptr;
    logic [15:0] zp;
    logic hit;
    w = 32'h0000_0000;
    ncyc = 3'h1;
    npc = s_q.pc + 22'h00_0001;
    pb = ptr_base(s_q.opnd[14:13]);
    ptr = ptr_get(s_q.regs, pb);
    zp = ptr_get(s_q.regs, `CMBX_PTR_Z);
    hit = 1'b0;
    s_d = s_q;
    s_d.push = 1'b0;
    s_d.dm_rd = 1'b0;
    // Writes are held off while an instruction runs; reads always pass.
    if (s_q.waitreq) begin
      if (req.read || (req.write && !busy_w)) begin
        s_d.waitreq = 1'b0;
        s_d.rdata = rd_word(s_q, req.addr);
      end
    end else begin
      s_d.waitreq = 1'b1;
      if (req.write) begin
        w = merge(rd_word(s_q, req.addr), req.wdata, req.be);
        case (req.addr)
          `CMBX_OFF_CMD: begin
            s_d.op = cmbx_pkg::cmbx_op_t'(w[5:0]);
            s_d.two_word = w[`CMBX_CMD_TWO_WORD];
            s_d.st = cmbx_pkg::ST_EXEC;
            s_d.dm_rd = 1'b1;
            s_d.io_addr = s_q.opnd[21:16];
            if (s_d.op == cmbx_pkg::DIRECT_DATA_LOAD) begin
              s_d.dm_addr = s_q.opnd[31:16];
            end else if (s_d.op == cmbx_pkg::POINTER_LOAD_DEC) begin
              s_d.dm_addr = ptr - 16'h0001;
            end else begin
              s_d.dm_addr = ptr;
            end
          end
          `CMBX_OFF_OPND: s_d.opnd = w;
          `CMBX_OFF_FLAGS: s_d.flags = w[7:0];
          `CMBX_OFF_PC: s_d.pc = w[21:0];
          `CMBX_OFF_PAGE: s_d.page = w[5:0];
          `CMBX_OFF_REGSEL: s_d.regsel = w[4:0];
          `CMBX_OFF_REGDAT: s_d.regs[s_q.regsel] = w[7:0];
          default: ;
        endcase
      end
    end
    case (s_q.st)
      cmbx_pkg::ST_EXEC: begin
        case (s_q.op)
          cmbx_pkg::UNSIGNED_PRODUCT_OP, cmbx_pkg::SIGNED_PRODUCT_OP,
          cmbx_pkg::MIXED_SIGN_PRODUCT_OP, cmbx_pkg::FRAC_UNSIGNED_PRODUCT_OP,
          cmbx_pkg::FRAC_SIGNED_PRODUCT_OP,
          cmbx_pkg::FRAC_MIXED_PRODUCT_OP: begin
            s_d.regs[0] = mres.prod[7:0];
            s_d.regs[1] = mres.prod[15:8];
            s_d.flags[`CMBX_FLAG_Z] = mres.zero;
            s_d.flags[`CMBX_FLAG_C] = mres.carry;
            ncyc = `CMBX_CYC_PRODUCT;
          end
          cmbx_pkg::CIPHER_STEP_OP: begin
            // A back-to-back cipher step reuses the round set-up.
            s_d.regs[15:0] = ciph_out;
            ncyc = s_q.prev_cipher ? 3'h1 : 3'h2;
          end
          cmbx_pkg::Z_POINTER_JUMP: begin
            npc = {6'h00, zp};
            ncyc = `CMBX_CYC_JUMP;
          end
          cmbx_pkg::FAR_Z_POINTER_JUMP: begin
            npc = {s_q.page, zp};
            ncyc = `CMBX_CYC_JUMP;
          end
          cmbx_pkg::Z_POINTER_CALL, cmbx_pkg::FAR_Z_POINTER_CALL: begin
            // A 22-bit return address needs the three-cycle push.
            s_d.push = 1'b1;
            s_d.push_addr = s_q.pc + 22'h00_0001;
            npc = (s_q.op == cmbx_pkg::FAR_Z_POINTER_CALL) ?
                  {s_q.page, zp} : {6'h00, zp};
            ncyc = `CMBX_CYC_CALL;
          end
          cmbx_pkg::COMPARE_SKIP_EQUAL: hit = (rd_v == rr_v);
          cmbx_pkg::SKIP_REG_BIT_CLEAR:
            hit = !rd_v[s_q.opnd[12:10]];
          cmbx_pkg::SKIP_REG_BIT_SET: hit = rd_v[s_q.opnd[12:10]];
          cmbx_pkg::SKIP_IO_BIT_CLEAR: begin
            hit = !i_io_rdata[s_q.opnd[12:10]];
            ncyc = 3'h2;
          end
          cmbx_pkg::SKIP_IO_BIT_SET: begin
            hit = i_io_rdata[s_q.opnd[12:10]];
            ncyc = 3'h2;
          end
          cmbx_pkg::DIRECT_DATA_LOAD: begin
            s_d.regs[s_q.opnd[4:0]] = i_dmem_rdata;
            npc = s_q.pc + 22'h00_0002;
            ncyc = `CMBX_CYC_DIRECT;
          end
          cmbx_pkg::POINTER_LOAD_INC: begin
            s_d.regs[s_q.opnd[4:0]] = i_dmem_rdata;
            {s_d.regs[pb + 5'h01], s_d.regs[pb]} = ptr + 16'h0001;
          end
          cmbx_pkg::POINTER_LOAD_DEC: begin
            s_d.regs[s_q.opnd[4:0]] = i_dmem_rdata;
            {s_d.regs[pb + 5'h01], s_d.regs[pb]} = ptr - 16'h0001;
            ncyc = `CMBX_CYC_PREDEC;
          end
          cmbx_pkg::COMPARE_REGS:
            s_d.flags = cmp_flags(s_q.flags, rd_v, rr_v, 1'b0, 1'b0);
          cmbx_pkg::COMPARE_REGS_CARRY:
            s_d.flags = cmp_flags(s_q.flags, rd_v, rr_v,
                                  s_q.flags[`CMBX_FLAG_C], 1'b1);
          cmbx_pkg::COMPARE_IMMEDIATE:
            s_d.flags = cmp_flags(s_q.flags, rd_v, s_q.opnd[23:16],
                                  1'b0, 1'b0);
          default: begin
            if (br_cond(s_q.op, s_q.flags, s_q.opnd[12:10])) begin
              npc = s_q.pc + {{6{s_q.opnd[31]}}, s_q.opnd[31:16]}
                  + 22'h00_0001;
              ncyc = `CMBX_CYC_TAKEN;
            end
          end
        endcase
        if (hit) begin
          npc = s_q.pc + (s_q.two_word ? 22'h00_0003 : 22'h00_0002);
          ncyc = ncyc + (s_q.two_word ? 3'h2 : 3'h1);
        end
        s_d.pc = npc;
        s_d.last_cyc = ncyc;
        s_d.prev_cipher = (s_q.op == cmbx_pkg::CIPHER_STEP_OP);
        s_d.cnt = 3'(ncyc - 3'h2);
        s_d.st = (ncyc == 3'h1) ? cmbx_pkg::ST_IDLE : cmbx_pkg::ST_WAIT;
      end
      cmbx_pkg::ST_WAIT: begin
        if (s_q.cnt == 3'h0) begin
          s_d.st = cmbx_pkg::ST_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 3'h1;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      s_q <= '0;
      s_q.waitreq <= 1'b1;
      s_q.pc <= `CMBX_RST_PC;
      s_q.flags <= `CMBX_RST_FLAGS;
      s_q.page <= `CMBX_RST_PAGE;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_avs_readdata = s_q.rdata;
  assign o_avs_waitrequest = s_q.waitreq;
  assign o_dmem_addr = s_q.dm_addr;
  assign o_dmem_read = s_q.dm_rd;
  assign o_io_addr = s_q.io_addr;
  assign o_push_valid = s_q.push;
  assign o_push_addr = s_q.push_addr;
  assign o_busy = busy_w;

  logic acc_w;
  logic exec_w;
  logic [5:0] acc_op;
  logic [15:0] ptr_w;
  logic [15:0] z_w;
  assign acc_w = !s_q.waitreq && req.write && (req.addr == `CMBX_OFF_CMD);
  assign acc_op = req.wdata[5:0];
  assign exec_w = (s_q.st == cmbx_pkg::ST_EXEC);
  assign ptr_w = ptr_get(s_q.regs, ptr_base(s_q.opnd[14:13]));
  assign z_w = ptr_get(s_q.regs, `CMBX_PTR_Z);

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence busy_two_s;
    busy_w [*2] ##1 !busy_w;
  endsequence
  sequence push_then_idle_s;
    o_push_valid && busy_w ##1 busy_w ##1 !busy_w;
  endsequence

  product_cycles_a: assert property (
    acc_w && acc_op >= 6'(cmbx_pkg::UNSIGNED_PRODUCT_OP)
          && acc_op <= 6'(cmbx_pkg::FRAC_MIXED_PRODUCT_OP) |=> busy_two_s)
    else $error("product did not take two cycles");
  frac_shift_a: assert property (
    exec_w && mul_frac |=> s_q.regs[0][0] == 1'b0)
    else $error("fractional product not shifted");
  zjump_target_a: assert property (
    exec_w && s_q.op == cmbx_pkg::Z_POINTER_JUMP
      |=> s_q.pc == {6'h00, $past(z_w)} && busy_w ##1 !busy_w)
    else $error("pointer jump target or timing wrong");
  far_jump_a: assert property (
    exec_w && s_q.op == cmbx_pkg::FAR_Z_POINTER_JUMP
      |=> s_q.pc == {$past(s_q.page), $past(z_w)})
    else $error("far jump page bits wrong");
  call_push_a: assert property (
    exec_w && s_q.op == cmbx_pkg::Z_POINTER_CALL |=> push_then_idle_s)
    else $error("call push or three-cycle timing wrong");
  compare_nowrite_a: assert property (
    exec_w && s_q.op >= cmbx_pkg::COMPARE_REGS
      |=> s_q.regs == $past(s_q.regs) && !busy_w)
    else $error("compare wrote a register");
  signed_branch_a: assert property (
    acc_w && acc_op == 6'(cmbx_pkg::BRANCH_SIGNED_GE)
      && !(s_q.flags[`CMBX_FLAG_N] ^ s_q.flags[`CMBX_FLAG_V]) |=> busy_two_s)
    else $error("signed branch not taken in two cycles");
  postinc_ptr_a: assert property (
    exec_w && s_q.op == cmbx_pkg::POINTER_LOAD_INC && s_q.opnd[4:0] < 5'h1A
      |=> ptr_w == $past(ptr_w) + 16'h0001 && !busy_w)
    else $error("pointer not incremented after load");
endmodule // cmbx_top

// ==== testbench/cmbx_mem_model.sv ====
`timescale 1ns/1ps
module cmbx_mem_model (
  input wire logic i_clk_sys,
  input wire logic [15:0] i_addr,
  input wire logic i_read,
  input wire logic [5:0] i_io_addr,
  output logic [7:0] o_rdata,
  output logic [7:0] o_io_rdata
);
  logic [7:0] junk_q = 8'h00;
  // Outside the read pulse the bus is not driven, so a counting pattern
  // stands there and a byte sampled at the wrong time cannot match.
  always @(posedge i_clk_sys) begin
    junk_q <= junk_q + 8'h01;
  end
  assign o_rdata = i_read ? (i_addr[7:0] ^ i_addr[15:8] ^ 8'h5A) : junk_q;
  assign o_io_rdata = i_read ? {2'b01, i_io_addr} : ~junk_q;
endmodule // cmbx_mem_model

// ==== testbench/cmbx_top_tb_top.sv ====
`timescale 1ns/1ps
`include "cmbx_params.svh"
module cmbx_top_tb_top;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdat;
  logic wrq, dmr, busy, pv;
  logic [15:0] dma, k, z, x, xm, r;
  logic [5:0] ioa, pg;
  logic [7:0] dmd, iod, a, b, f;
  logic [21:0] pa, pc;
  logic [2:0] s;
  logic t, sa, sb;
  logic signed [17:0] full;
  logic [31:0] qr[$];
  logic [21:0] qp[$];
  int fi[6] = '{0, 0, 5, 7, 3, 6};
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int op;
  always #50 i_clk_sys = ~i_clk_sys;
  cmbx_top u_cmbx_top (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_byteenable(4'hF), .i_avs_writedata(wd), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wrq), .o_dmem_addr(dma), .o_dmem_read(dmr),
    .i_dmem_rdata(dmd), .o_io_addr(ioa), .i_io_rdata(iod),
    .o_push_valid(pv), .o_push_addr(pa), .o_busy(busy));
  cmbx_mem_model u_cmbx_mem_model (.i_clk_sys(i_clk_sys), .i_addr(dma),
    .i_read(dmr), .i_io_addr(ioa), .o_rdata(dmd), .o_io_rdata(iod));
  function automatic logic [7:0] memb(input logic [15:0] ad);
    return ad[7:0] ^ ad[15:8] ^ 8'h5A;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The request stands until an edge sees waitrequest low, then drops.
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_clk_sys);
    adr <= ad;
    wd <= d;
    rd <= !w;
    wr <= w;
    do @(posedge i_clk_sys); while (wrq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
    qr.push_back(exp);
    bus(1'b0, ad, 32'h0000_0000);
  endtask
  task automatic wreg(input logic [4:0] i, input logic [7:0] v);
    bus(1'b1, `CMBX_OFF_REGSEL, {27'h0, i});
    bus(1'b1, `CMBX_OFF_REGDAT, {24'h0, v});
  endtask
  task automatic rreg(input logic [4:0] i, input logic [7:0] v);
    bus(1'b1, `CMBX_OFF_REGSEL, {27'h0, i});
    rdchk(`CMBX_OFF_REGDAT, {24'h0, v});
  endtask
  task automatic run(input logic [31:0] cmd, opnd, input logic [2:0] n);
    bus(1'b1, `CMBX_OFF_OPND, opnd);
    bus(1'b1, `CMBX_OFF_CMD, cmd);
    @(negedge i_clk_sys);
    while (busy !== 1'b0) @(negedge i_clk_sys);
    rdchk(`CMBX_OFF_STATUS, {28'h0, n, 1'b0});
  endtask
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (rd && wrq === 1'b0) chk(rdat, qr.pop_front());
    if (pv === 1'b1) chk({10'h0, pa}, {10'h0, qp.pop_front()});
    if (cyc == 40000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  initial begin
    void'($urandom(32'h0707_ce28));
    repeat (10) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    rdchk(`CMBX_OFF_PC, 32'h0000_0000);
    rdchk(`CMBX_OFF_FLAGS, 32'h0000_0000);
    rdchk(8'h20, 32'h0000_0000);
    $display("test reset done");
    for (op = 1; op <= 6; op++) begin
      a = $urandom;
      b = $urandom;
      wreg(2, a);
      wreg(3, b);
      bus(1'b1, `CMBX_OFF_FLAGS, 32'h0000_0000);
      run(op, 32'h0000_0062, 3'h2);
      sa = (op != 1 && op != 4);
      sb = (op == 2 || op == 5);
      full = $signed({sa & a[7], a}) * $signed({sb & b[7], b});
      r = (op > 3) ? {full[14:0], 1'b0} : full[15:0];
      rreg(0, r[7:0]);
      rreg(1, r[15:8]);
      rdchk(`CMBX_OFF_FLAGS, {30'h0, r == 16'h0, full[15]});
    end
    $display("test products done");
    repeat (3) for (op = 8; op <= 23; op++) begin
      f = $urandom;
      k = $urandom;
      s = $urandom;
      pc = $urandom;
      if (op < 10) t = f[s] ^ op[0];
      else if (op < 12) t = f[2] ^ f[3] ^ !op[0];
      else t = f[fi[(op - 12) / 2]] ^ ((op < 14) ? !op[0] : op[0]);
      bus(1'b1, `CMBX_OFF_FLAGS, {24'h0, f});
      bus(1'b1, `CMBX_OFF_PC, {10'h0, pc});
      run(op, {k, 3'h0, s, 10'h0}, t ? 3'h2 : 3'h1);
      pc = t ? pc + {{6{k[15]}}, k} + 22'h1 : pc + 22'h1;
      rdchk(`CMBX_OFF_PC, {10'h0, pc});
    end
    $display("test branches done");
    for (op = 24; op <= 27; op++) begin
      z = $urandom;
      pg = $urandom;
      pc = $urandom;
      wreg(30, z[7:0]);
      wreg(31, z[15:8]);
      bus(1'b1, `CMBX_OFF_PAGE, {26'h0, pg});
      bus(1'b1, `CMBX_OFF_PC, {10'h0, pc});
      if (op > 25) qp.push_back(pc + 22'h1);
      run(op, 32'h0000_0000, (op > 25) ? 3'h3 : 3'h2);
      rdchk(`CMBX_OFF_PC, {10'h0, op[0] ? pg : 6'h00, z});
    end
    $display("test jumps done");
    k = $urandom;
    run(33, {k, 16'h0005}, 3'h2);
    rreg(5, memb(k));
    for (op = 34; op <= 35; op++) begin
      x = $urandom;
      wreg(26, x[7:0]);
      wreg(27, x[15:8]);
      xm = (op == 35) ? x - 16'h1 : x;
      run(op, 32'h0000_0007, (op == 35) ? 3'h2 : 3'h1);
      rreg(7, memb(xm));
      xm = (op == 35) ? xm : x + 16'h1;
      rreg(26, xm[7:0]);
      rreg(27, xm[15:8]);
    end
    $display("test loads done");
    a = $urandom;
    wreg(2, a);
    wreg(3, a);
    bus(1'b1, `CMBX_OFF_PC, 32'h0000_0100);
    run(32'h0000_005C, 32'h0000_0062, 3'h3);
    rdchk(`CMBX_OFF_PC, 32'h0000_0103);
    run(36, 32'h0000_0062, 3'h1);
    rreg(2, a);
    rdchk(`CMBX_OFF_FLAGS, {24'h0, f[7:6], 6'h02});
    for (op = 29; op <= 32; op++) begin
      s = $urandom;
      sa = $urandom;
      pg = $urandom;
      f = (op > 30) ? {2'b01, pg} : a;
      t = f[s] ^ op[0];
      bus(1'b1, `CMBX_OFF_PC, 32'h0000_0200);
      run({25'h0, sa, 6'(op)}, {10'h0, pg, 3'h0, s, 10'h002},
          3'((op > 30) + 1 + (t ? sa + 1 : 0)));
      rdchk(`CMBX_OFF_PC, 32'h0000_0200 + (t ? sa + 2 : 1));
    end
    $display("test bit skips done");
    a = $urandom;
    b = $urandom;
    wreg(0, a);
    wreg(15, b);
    bus(1'b1, `CMBX_OFF_FLAGS, 32'h0000_0000);
    run(7, 32'h0005_0000, 3'h2);
    bus(1'b1, `CMBX_OFF_FLAGS, 32'h0000_0020);
    run(7, 32'h0005_0000, 3'h1);
    rreg(0, a);
    rreg(15, b);
    rdchk(`CMBX_OFF_FLAGS, 32'h0000_0020);
    $display("test cipher done");
    $display("test skip and compare done");
    repeat (3) @(posedge i_clk_sys);
    tally_and_finish;
  end
endmodule // cmbx_top_tb_top
